// >>> design/asq_accum.sv
// One 32-bit accumulator with its elapsed-time counter.
module asq_accum
  import asq_pkg::*;
#(
  parameter int unsigned SUM_W = ACC_W,     // Accumulator and timer width.
  parameter int unsigned ADD_W = MAG_BITS   // Addend width.
) (
  input  wire logic             i_ref_clk,  // System clock.
  input  wire logic             i_rst_b,    // Asynchronous reset, active low.
  input  wire logic             i_tick,     // Half-second pulse.
  input  wire logic             i_enable,   // Accumulation enabled.
  input  wire logic             i_qualify,  // Source belongs to this sum.
  input  wire logic [ADD_W-1:0] i_addend,   // Source magnitude.
  output logic      [SUM_W-1:0] o_sum,      // Running total.
  output logic      [SUM_W-1:0] o_time      // Half-seconds accumulated.
);

  // The addend must fit inside the sum with room to spare.
  if (ADD_W >= SUM_W) begin : g_bad_width
    $error("asq_accum: addend must be narrower than the sum");
  end

  logic [SUM_W-1:0] sum_q, sum_d;    // Running total.
  logic [SUM_W-1:0] time_q, time_d;  // Elapsed half-seconds.

  // ----------------------------------------------------------------------
  // Update
  // ----------------------------------------------------------------------
  // Both wrap silently; software is expected to read often enough.
  always_comb begin
    sum_d  = sum_q;
    time_d = time_q;
    if (i_tick && i_enable && i_qualify) begin
      sum_d  = sum_q + SUM_W'(i_addend);
      time_d = time_q + SUM_W'(1);
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sum_q  <= '0;
      time_q <= '0;
    end else begin
      sum_q  <= sum_d;
      time_q <= time_d;
    end
  end

  assign o_sum  = sum_q;
  assign o_time = time_q;

  // A qualified tick adds exactly the addend and one half-second.
  property p_acc_add;
    @(posedge i_ref_clk) disable iff (!i_rst_b)
      (i_tick && i_enable && i_qualify) |=>
        (sum_q == $past(sum_q) + SUM_W'($past(i_addend))) &&
        (time_q == $past(time_q) + SUM_W'(1));
  endproperty
  a_acc_add: assert property (p_acc_add)
    else $error("accumulator did not add its source");

  // Without a qualified tick nothing moves.
  property p_acc_hold;
    @(posedge i_ref_clk) disable iff (!i_rst_b)
      !(i_tick && i_enable && i_qualify) |=> $stable(sum_q) && $stable(time_q);
  endproperty
  a_acc_hold: assert property (p_acc_hold)
    else $error("accumulator changed without a qualified tick");

endmodule : asq_accum

// >>> design/asq_adc_conversion_sequencer.sv
// Conversion sequencer: slot walk, result formatting, time base, accumulators.
//
// Behaviour
// - Repeat the slot cycle while converter enabled.
// - Visit slots in order, using their fields.
// - Disabled slot: no conversion, go on.
// - Store each result in its slot's register.
// - Three-bit selector picks one of seven inputs.
// - Offset source shorts converter input to ground.
// - Fixed slot roles; accumulators read fixed results.
// - Three-bit field sets eight to fifteen bits.
// - Conversion lasts 30.52 us times 2^(N+1).
// - Reference bit: differential 170 mV, single 340 mV.
// - LSB weight follows fifteen-bit scale.
// - Results in sign-magnitude, sign at bit 15.
// - Short results left-aligned, zero padded.
// - Timing comes from trimmed 131.072 kHz base.
// - Four accumulators and four time counters.
// - Enabled accumulators add source each half second.
// - Positive current adds into charge sum.
module asq_adc_conversion_sequencer
  import asq_pkg::*;
#(
  parameter int unsigned BASE_DIV   = BASE_DIV_CYCLES,  // System cycles per time base tick.
  parameter int unsigned HALF_TICKS = HALF_SEC_TICKS    // Converter clocks per half second.
) (
  input  wire logic             i_ref_clk,          // System clock, 200 MHz.
  input  wire logic             i_rst_b,            // Asynchronous reset, active low.
  input  wire logic             i_conv_enable,      // Converter enabled.
  input  wire asq_ctrl_bank_t   i_slot_ctrl,        // Eight slot control registers.
  input  wire logic [ACCS-1:0]  i_acc_enable,       // Accumulator enables.
  input  wire logic             i_temp_acc_ext,     // Temperature sum reads thermistor slot.
  input  wire logic [14:0]      i_adc_magnitude,    // Front-end count, right-aligned N bits.
  input  wire logic             i_adc_sign,         // Front-end sign, 1 negative.
  output logic                  o_conv_active,      // Front end integrating.
  output logic [2:0]            o_mux_sel,          // Analog selector code.
  output logic                  o_ref_single,       // 1 selects 340 mV single-ended.
  output logic [2:0]            o_res_code,         // Resolution code of the conversion.
  output logic                  o_input_short,      // Converter input tied to ground.
  output logic                  o_thermistor_bias,  // Thermistor current source on.
  output logic [2:0]            o_slot,             // Slot being visited.
  output asq_result_bank_t      o_results,          // Eight result registers.
  output asq_acc_bank_t         o_acc_sum,          // Four accumulator sums.
  output asq_acc_bank_t         o_acc_time          // Four elapsed-time counts.
);

  // Divider counters must have at least two states to produce a pulse.
  if (BASE_DIV < 2 || HALF_TICKS < 2) begin : g_bad_div
    $error("asq_adc_conversion_sequencer: BASE_DIV and HALF_TICKS must be at least 2");
  end

  localparam int unsigned BW = $clog2(BASE_DIV);         // Base divider width.
  localparam int unsigned HW = $clog2(HALF_TICKS);       // Half-second counter width.
  localparam int unsigned CW = MAG_BITS + 4;             // Width to count base ticks of the longest conversion.

  // ----------------------------------------------------------------------
  // Time base
  // ----------------------------------------------------------------------
  logic [BW-1:0] base_cnt_q, base_cnt_d;  // System cycles within a base tick.
  logic [1:0]    ad_cnt_q, ad_cnt_d;      // Base ticks within a converter clock.
  logic [HW-1:0] half_cnt_q, half_cnt_d;  // Converter clocks within half a second.
  logic          base_tick;               // One pulse per 131.072 kHz period.
  logic          ad_tick;                 // One pulse per converter clock.
  logic          half_tick_q, half_tick_d;// Registered half-second pulse.

  assign base_tick = (base_cnt_q == BW'(BASE_DIV - 1));
  assign ad_tick   = base_tick && (ad_cnt_q == 2'(AD_DIV - 1));

  // Free-running dividers; the accumulators share them with the converter.
  always_comb begin
    base_cnt_d  = base_tick ? '0 : base_cnt_q + BW'(1);
    ad_cnt_d    = base_tick ? ad_cnt_q + 2'(1) : ad_cnt_q;
    half_cnt_d  = half_cnt_q;
    half_tick_d = 1'b0;
    if (ad_tick) begin
      if (half_cnt_q == HW'(HALF_TICKS - 1)) begin
        half_cnt_d  = '0;
        half_tick_d = 1'b1;
      end else begin
        half_cnt_d = half_cnt_q + HW'(1);
      end
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      base_cnt_q  <= '0;
      ad_cnt_q    <= '0;
      half_cnt_q  <= '0;
      half_tick_q <= 1'b0;
    end else begin
      base_cnt_q  <= base_cnt_d;
      ad_cnt_q    <= ad_cnt_d;
      half_cnt_q  <= half_cnt_d;
      half_tick_q <= half_tick_d;
    end
  end

  // ----------------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {SEQ_IDLE, SEQ_SCAN, SEQ_CONVERT, SEQ_STORE} asq_state_t;

  asq_state_t       state_q, state_d;    // Sequencer state.
  logic [2:0]       slot_q, slot_d;      // Slot being visited.
  asq_slot_ctrl_t   cfg_q, cfg_d;        // Settings latched at conversion start.
  logic [CW-1:0]    conv_cnt_q, conv_cnt_d;  // Base ticks since conversion start.
  logic [CW-1:0]    conv_target;         // Base ticks the conversion needs.
  asq_result_bank_t results_q, results_d;    // Result registers.
  logic             active_q, short_q, bias_q;  // Registered front-end controls.
  logic             active_d, short_d, bias_d;
  asq_slot_ctrl_t   cur_ctrl;            // Control register of the current slot.
  logic [14:0]      aligned_mag;         // Magnitude moved to the top bits.

  // N = 8 + code, and the time is 2^(N+1) converter clocks of four base ticks.
  assign conv_target = CW'(1) << (RES_BASE + 3 + cfg_q.res);
  // Count arrives right-aligned in N bits; shift so the MSB sits at bit 14.
  assign aligned_mag = i_adc_magnitude << (SHIFT_MAX - cfg_q.res);
  assign cur_ctrl    = i_slot_ctrl[slot_q];

  // The next slot and its fields are chosen here; disabling aborts at once,
  // so a half-finished conversion never overwrites the previous result.
  always_comb begin
    state_d    = state_q;
    slot_d     = slot_q;
    cfg_d      = cfg_q;
    conv_cnt_d = conv_cnt_q;
    results_d  = results_q;
    unique case (state_q)
      SEQ_IDLE: begin
        slot_d = 3'h0;
        if (i_conv_enable) begin
          state_d = SEQ_SCAN;
        end
      end
      SEQ_SCAN: begin
        if (cur_ctrl.enable) begin
          cfg_d      = cur_ctrl;
          conv_cnt_d = '0;
          state_d    = SEQ_CONVERT;
        end else begin
          slot_d = slot_q + 3'h1;
        end
      end
      SEQ_CONVERT: begin
        if (base_tick) begin
          conv_cnt_d = conv_cnt_q + CW'(1);
          if (conv_cnt_d == conv_target) begin
            state_d = SEQ_STORE;
          end
        end
      end
      SEQ_STORE: begin
        results_d[slot_q] = '{sign: i_adc_sign, mag: aligned_mag};
        slot_d            = slot_q + 3'h1;   // Slot 7 wraps to 0
        state_d           = SEQ_SCAN;
      end
    endcase
    if (!i_conv_enable) begin
      state_d   = SEQ_IDLE;
      slot_d    = 3'h0;
      results_d = results_q;  // An abort on the store cycle writes nothing either.
    end
    active_d = (state_d == SEQ_CONVERT);
    // Offset slots ground the input so the count is the converter's own error.
    short_d  = active_d && (cfg_d.sel == SEL_OFFSET);
    // The thermistor source only draws current while it is measured.
    bias_d   = active_d && (cfg_d.sel == SEL_EXT_TEMP);
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_q    <= SEQ_IDLE;
      slot_q     <= 3'h0;
      cfg_q      <= '0;
      conv_cnt_q <= '0;
      results_q  <= {SLOTS{RESULT_RST}};
      active_q   <= 1'b0;
      short_q    <= 1'b0;
      bias_q     <= 1'b0;
    end else begin
      state_q    <= state_d;
      slot_q     <= slot_d;
      cfg_q      <= cfg_d;
      conv_cnt_q <= conv_cnt_d;
      results_q  <= results_d;
      active_q   <= active_d;
      short_q    <= short_d;
      bias_q     <= bias_d;
    end
  end

  assign o_conv_active     = active_q;
  assign o_mux_sel         = cfg_q.sel;
  assign o_ref_single      = cfg_q.ref_single;
  assign o_res_code        = cfg_q.res;
  assign o_input_short     = short_q;
  assign o_thermistor_bias = bias_q;
  assign o_slot            = slot_q;
  assign o_results         = results_q;

  // ----------------------------------------------------------------------
  // Accumulators and elapsed-time counters
  // ----------------------------------------------------------------------
  logic [ACCS-1:0]       acc_qual;   // Source belongs to each sum.
  logic [ACCS-1:0][14:0] acc_add;    // Source magnitude for each sum.
  asq_result_t           cur_res;    // Current result, read by both capacity sums.

  // Sources are wired to fixed result slots, not to selector codes.
  assign cur_res = results_q[SLOT_CURRENT];
  always_comb begin
    acc_qual                = '1;
    acc_add                 = '0;
    acc_add[ACC_DISCHARGE]  = cur_res.mag;
    acc_qual[ACC_DISCHARGE] = cur_res.sign;
    acc_add[ACC_CHARGE]     = cur_res.mag;
    acc_qual[ACC_CHARGE]    = !cur_res.sign;
    acc_add[ACC_TEMP]       = i_temp_acc_ext ? results_q[SLOT_EXT_TEMP].mag
                                             : results_q[SLOT_INT_TEMP].mag;
    acc_add[ACC_SPARE]      = results_q[SLOT_SPARE].mag;
  end

  for (genvar g = 0; g < ACCS; g++) begin : g_acc
    asq_accum #(
      .SUM_W (ACC_W),
      .ADD_W (MAG_BITS)
    ) u_accum (
      .i_ref_clk (i_ref_clk),
      .i_rst_b   (i_rst_b),
      .i_tick    (half_tick_q),
      .i_enable  (i_acc_enable[g]),
      .i_qualify (acc_qual[g]),
      .i_addend  (acc_add[g]),
      .o_sum     (o_acc_sum[g]),
      .o_time    (o_acc_time[g])
    );
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  property p_skip;
    @(posedge i_ref_clk) disable iff (!i_rst_b)
      (state_q == SEQ_SCAN && !cur_ctrl.enable && i_conv_enable) |=>
        (state_q == SEQ_SCAN) && (slot_q == $past(slot_q) + 3'h1);
  endproperty
  a_skip: assert property (p_skip)
    else $error("disabled slot was not skipped");

  property p_latch;
    @(posedge i_ref_clk) disable iff (!i_rst_b)
      (state_q == SEQ_SCAN && cur_ctrl.enable && i_conv_enable) |=>
        (state_q == SEQ_CONVERT) && (cfg_q == $past(cur_ctrl)) && o_conv_active;
  endproperty
  a_latch: assert property (p_latch)
    else $error("enabled slot did not start with its own fields");

  property p_duration;
    @(posedge i_ref_clk) disable iff (!i_rst_b)
      (state_q == SEQ_STORE) |-> (conv_cnt_q == (CW'(1) << (RES_BASE + 3 + cfg_q.res)));
  endproperty
  a_duration: assert property (p_duration)
    else $error("conversion stored before its full time");

  property p_order;
    @(posedge i_ref_clk) disable iff (!i_rst_b)
      (state_q == SEQ_STORE && i_conv_enable) |=>
        (state_q == SEQ_SCAN) && (slot_q == $past(slot_q) + 3'h1);
  endproperty
  a_order: assert property (p_order)
    else $error("sequencer did not move to the next slot");

  property p_store;
    @(posedge i_ref_clk) disable iff (!i_rst_b)
      (state_q == SEQ_STORE && i_conv_enable) |=>
        (results_q[$past(slot_q)].sign == $past(i_adc_sign)) &&
        (results_q[$past(slot_q)].mag ==
         15'($past(i_adc_magnitude) << (SHIFT_MAX - $past(cfg_q.res))));
  endproperty
  a_store: assert property (p_store)
    else $error("result not stored left-aligned in its slot");

  property p_short;
    @(posedge i_ref_clk) disable iff (!i_rst_b)
      o_input_short == (o_conv_active && o_mux_sel == SEL_OFFSET);
  endproperty
  a_short: assert property (p_short)
    else $error("input short does not follow offset conversion");

  property p_abort;
    @(posedge i_ref_clk) disable iff (!i_rst_b)
      !i_conv_enable |=> (state_q == SEQ_IDLE) && !o_conv_active && $stable(results_q);
  endproperty
  a_abort: assert property (p_abort)
    else $error("sequencer kept running while disabled");

  property p_half;
    @(posedge i_ref_clk) disable iff (!i_rst_b)
      half_tick_q |-> ##1 !half_tick_q [*8];
  endproperty
  a_half: assert property (p_half)
    else $error("half-second pulses too close");

endmodule : asq_adc_conversion_sequencer

// >>> design/asq_pkg.sv
// Shared constants and types for the converter sequencer.
package asq_pkg;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_PS  = 5000;     // System clock period, 200 MHz.
  localparam int unsigned BASE_PERIOD_PS = 7629395;  // Time base period, 131.072 kHz.
  // Longest whole number of system cycles inside one time base period.
  localparam int unsigned BASE_DIV_CYCLES = BASE_PERIOD_PS / CLK_PERIOD_PS;
  localparam int unsigned AD_DIV          = 4;       // Converter clock is time base / 4.
  localparam int unsigned CONV_UNIT_NS    = 30520;   // One converter clock, 30.52 us.
  localparam int unsigned HALF_SEC_MS     = 500;     // Accumulation period.
  // Converter clocks in one accumulation period, rounded down.
  localparam int unsigned HALF_SEC_TICKS  = (HALF_SEC_MS * 1000000) / CONV_UNIT_NS;

  // ----------------------------------------------------------------------
  // Resolution and result format
  // ----------------------------------------------------------------------
  localparam int unsigned SLOTS      = 8;          // Control and result slots.
  localparam int unsigned RES_BASE   = 8;          // Resolution of code zero.
  localparam int unsigned MAG_BITS   = 15;         // Full magnitude width.
  localparam logic [2:0]  SHIFT_MAX  = 3'h7;       // MAG_BITS - RES_BASE.
  localparam logic [15:0] RESULT_RST = 16'h0000;   // Result value after reset.
  localparam int unsigned ACCS       = 4;          // Accumulator and timer pairs.
  localparam int unsigned ACC_W      = 32;         // Accumulator and timer width.

  // ----------------------------------------------------------------------
  // Input selector codes
  // ----------------------------------------------------------------------
  localparam logic [2:0] SEL_CURRENT  = 3'h0;      // Sense resistor voltage.
  localparam logic [2:0] SEL_INT_TEMP = 3'h1;      // On-chip temperature sensor.
  localparam logic [2:0] SEL_EXT_TEMP = 3'h2;      // Thermistor.
  localparam logic [2:0] SEL_PACK     = 3'h3;      // Pack voltage.
  localparam logic [2:0] SEL_RESERVED = 3'h4;      // Reserved code.
  localparam logic [2:0] SEL_SPARE    = 3'h5;      // Spare analog input.
  localparam logic [2:0] SEL_OFFSET   = 3'h6;      // Input shorted to ground.

  // ----------------------------------------------------------------------
  // Slot and accumulator indices
  // ----------------------------------------------------------------------
  localparam int unsigned SLOT_CURRENT  = 0;       // pack_current_result.
  localparam int unsigned SLOT_INT_TEMP = 1;       // internal_temp_result.
  localparam int unsigned SLOT_EXT_TEMP = 2;       // external_temp_result.
  localparam int unsigned SLOT_PACK     = 3;       // pack_voltage_result.
  localparam int unsigned SLOT_SPARE    = 5;       // spare_input_result.
  localparam int unsigned SLOT_OFFSET   = 6;       // offset_result.
  localparam int unsigned SLOT_EXTRA    = 7;       // extra_slot_result.
  localparam int unsigned ACC_DISCHARGE = 0;       // discharge_capacity_sum / time.
  localparam int unsigned ACC_CHARGE    = 1;       // charge_capacity_sum / time.
  localparam int unsigned ACC_TEMP      = 2;       // Temperature sum / time.
  localparam int unsigned ACC_SPARE     = 3;       // Spare input sum / time.

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic       enable;      // Bit 7: perform this slot's conversion.
    logic [2:0] res;         // Bits 6-4: resolution code.
    logic       ref_single;  // Bit 3: 1 single-ended 340 mV, 0 differential 170 mV.
    logic [2:0] sel;         // Bits 2-0: input selector.
  } asq_slot_ctrl_t;

  typedef struct packed {
    logic        sign;       // Bit 15: sign.
    logic [14:0] mag;        // Bits 14-0: left-aligned magnitude.
  } asq_result_t;

  typedef asq_slot_ctrl_t [SLOTS-1:0] asq_ctrl_bank_t;
  typedef asq_result_t    [SLOTS-1:0] asq_result_bank_t;
  typedef logic [ACCS-1:0][ACC_W-1:0] asq_acc_bank_t;

endpackage : asq_pkg

// >>> testbench/adc_conversion_sequencer_test.sv
// Self-checking bench for the converter sequencer.
module adc_conversion_sequencer_test;
  timeunit 1ns;
  timeprecision 1ps;
  import asq_pkg::*;

  localparam int unsigned BD = 2;  // Short time base divider keeps runs brief.
  localparam int unsigned HT = 64; // Short half second: 512 cycles.

  logic             clk, rst_b, conv_en;       // Clock, reset, enable.
  asq_ctrl_bank_t   ctrl;                      // Slot controls.
  logic [14:0]      mag;                       // Front-end count.
  logic             sgn, act, shrt, bias, rf;  // Front-end sign and status.
  logic [2:0]       msel, rcode, slot;         // Latched fields.
  asq_result_bank_t res;                       // Result registers.
  int               n_errors, comparisons, cyc; // Counters.
  logic [15:0]      saved;                     // Result before the abort.
  logic [3:0]       acc_en;                    // Accumulator enables.
  asq_acc_bank_t    asum, atime;               // Sums and elapsed-time counts.

  asq_adc_conversion_sequencer #(.BASE_DIV(BD), .HALF_TICKS(HT)) i_dut (
    .i_ref_clk(clk), .i_rst_b(rst_b), .i_conv_enable(conv_en), .i_slot_ctrl(ctrl),
    .i_acc_enable(acc_en), .i_temp_acc_ext(1'b1), .i_adc_magnitude(mag), .i_adc_sign(sgn),
    .o_conv_active(act), .o_mux_sel(msel), .o_ref_single(rf), .o_res_code(rcode),
    .o_input_short(shrt), .o_thermistor_bias(bias), .o_slot(slot), .o_results(res),
    .o_acc_sum(asum), .o_acc_time(atime));

  asq_front_end_model i_fe (
    .i_ref_clk(clk), .i_rst_b(rst_b), .i_active(act), .i_sel(msel), .i_res_code(rcode),
    .i_ref_single(rf), .o_magnitude(mag), .o_sign(sgn));

  // ----------------------------------------------------------------------
  // Clock and hang guard
  // ----------------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // The planned visits take about 37000 cycles; nearly twice that means a hang.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 70000) begin
      n_errors++;
      results();
    end
  end

  // ----------------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------------
  task automatic check(string name, logic [31:0] exp, logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      $display("ERROR %s expected %h seen %h", name, exp, got);
      n_errors++;
    end
  endtask

  task automatic results();
    if (n_errors == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // Expected stored word: model count left-aligned to fifteen bits.
  function automatic logic [15:0] expect_res(logic [2:0] code, logic r, logic [2:0] s);
    logic [14:0] c;
    c = (15'(s) * 15'h0123 + 15'h0041) & ((15'h0100 << code) - 15'h0001);
    return {s[0] & ~r, 15'(c << (3'h7 - code))};
  endfunction

  // Magnitude that slot k's register holds, as the accumulators add it.
  function automatic logic [31:0] src(int k);
    return {17'h0, 15'(expect_res(ctrl[k].res, ctrl[k].ref_single, ctrl[k].sel))};
  endfunction

  // Wait, bounded, for the next conversion to start.
  task automatic wait_active();
    for (int i = 0; i < 40 && act !== 1'b1; i++) @(negedge clk);
  endtask

  // Follow one conversion of slot k and check fields, length and result.
  task automatic run_slot(int k);
    asq_slot_ctrl_t c;
    int n;
    c = ctrl[k];
    n = 0;
    wait_active();
    check("active", 16'h1, {15'h0, act});
    check("slot", 16'(k), {13'h0, slot});
    check("fields", {9'h0, c.res, c.ref_single, c.sel}, {9'h0, rcode, rf, msel});
    check("short", {15'h0, c.sel == SEL_OFFSET}, {15'h0, shrt});
    check("bias", {15'h0, c.sel == SEL_EXT_TEMP}, {15'h0, bias});
    while (act === 1'b1 && n < 70000) begin
      @(negedge clk);
      n++;
    end
    n = n - (32'h800 << c.res) * BD;
    check("length", 16'h1, {15'h0, n >= -int'(BD) && n <= 2});
    @(negedge clk);
    check("result", expect_res(c.res, c.ref_single, c.sel), res[k]);
  endtask

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    rst_b = 1'b0;
    conv_en = 1'b0;
    acc_en = 4'h0;
    ctrl = '0;
    repeat (10) @(negedge clk);
    rst_b = 1'b1;
    @(negedge clk);
    for (int k = 0; k < 8; k++) check("reset", RESULT_RST, res[k]);
    // Slots 1 and 4 stay disabled but carry live fields to tempt a conversion.
    ctrl[0] = {1'b1, 3'h0, 1'b0, SEL_CURRENT};
    ctrl[1] = {1'b0, 3'h0, 1'b1, SEL_INT_TEMP};
    ctrl[2] = {1'b1, 3'h0, 1'b1, SEL_EXT_TEMP};
    ctrl[3] = {1'b1, 3'h1, 1'b1, SEL_PACK};
    ctrl[4] = {1'b0, 3'h0, 1'b0, SEL_RESERVED};
    ctrl[5] = {1'b1, 3'h0, 1'b0, SEL_SPARE};
    ctrl[6] = {1'b1, 3'h0, 1'b0, SEL_OFFSET};
    ctrl[7] = {1'b1, 3'h0, 1'b0, SEL_RESERVED};
    conv_en = 1'b1;
    for (int k = 0; k < 8; k++) if (ctrl[k].enable) run_slot(k);
    // Every result now stands; accumulate over one more visit of slot 0.
    acc_en = 4'hf;
    run_slot(0);
    acc_en = 4'h0;
    @(negedge clk);
    check("skipped1", RESULT_RST, res[1]);
    check("skipped4", RESULT_RST, res[4]);
    check("acc_ticks", 32'h1, {31'h0, (atime[ACC_CHARGE] inside {[7:9]})});
    check("dis_time", 32'h0, atime[ACC_DISCHARGE]);
    check("dis_sum", 32'h0, asum[ACC_DISCHARGE]);
    check("chg_sum", atime[ACC_CHARGE] * src(SLOT_CURRENT), asum[ACC_CHARGE]);
    check("tmp_time", atime[ACC_CHARGE], atime[ACC_TEMP]);
    check("tmp_sum", atime[ACC_TEMP] * src(SLOT_EXT_TEMP), asum[ACC_TEMP]);
    check("spr_time", atime[ACC_CHARGE], atime[ACC_SPARE]);
    check("spr_sum", atime[ACC_SPARE] * src(SLOT_SPARE), asum[ACC_SPARE]);
    // Slot 2 is reprogrammed before its visit, so a write on an aborted store would show.
    saved = res[2];
    ctrl[2].sel = SEL_SPARE;
    wait_active();
    for (int i = 0; i < 5000 && act === 1'b1; i++) @(negedge clk);
    // The conversion has just ended: drop the enable on the store cycle itself.
    conv_en = 1'b0;
    repeat (2) @(negedge clk);
    check("abort_active", 16'h0, {15'h0, act});
    check("abort_slot", 16'h0, {13'h0, slot});
    check("abort_keep", saved, res[2]);
    // Restart from slot 0, then abort in mid-conversion.
    conv_en = 1'b1;
    wait_active();
    check("restart_slot", 16'h0, {13'h0, slot});
    repeat (100) @(negedge clk);
    conv_en = 1'b0;
    repeat (2) @(negedge clk);
    check("abort_mid", 16'h0, {15'h0, act});
    results();
  end
endmodule // adc_conversion_sequencer_test

// >>> testbench/asq_front_end_model.sv
// Behavioural model of the analog front end that feeds converter counts.
module asq_front_end_model
  import asq_pkg::*;
(
  input  wire logic        i_ref_clk,    // System clock.
  input  wire logic        i_rst_b,      // Reset, active low.
  input  wire logic        i_active,     // Conversion running.
  input  wire logic [2:0]  i_sel,        // Selected input.
  input  wire logic [2:0]  i_res_code,   // Resolution code.
  input  wire logic        i_ref_single, // Single-ended reference chosen.
  output logic      [14:0] o_magnitude,  // Count, right-aligned in N bits.
  output logic             o_sign        // Sign, 1 negative.
);
  timeunit 1ns;
  timeprecision 1ps;

  logic        live_q; // Count is still held one cycle after the conversion.
  logic [14:0] cnt;    // Count for the selected input.
  logic        sgn;    // Sign for the selected input.

  // ----------------------------------------------------------------------
  // Hold window
  // ----------------------------------------------------------------------
  // Remember the last active cycle so the store cycle still sees a count.
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      live_q <= 1'b0;
    end else begin
      live_q <= i_active;
    end
  end

  // Count fits N = 8 + code bits; outside the hold the lines show the inverse.
  always_comb begin
    cnt = (15'(i_sel) * 15'h0123 + 15'h0041)
          & ((15'h0100 << i_res_code) - 15'h0001);
    sgn = i_sel[0] & ~i_ref_single;
    o_magnitude = (i_active | live_q) ? cnt : ~cnt;
    o_sign = (i_active | live_q) ? sgn : ~sgn;
  end
endmodule // asq_front_end_model
